//--- sir_pkg.sv
// Purpose: Shared constants for the serial input read command engine
// Assumes: Word-addressed register port, 16-bit words
// Notes: Status codes other than the cancel minor code are local choices
package sir_pkg;
	// Register word addresses
	localparam logic [3:0] SIR_REG_CMD = 4'h0;
	localparam logic [3:0] SIR_REG_TIMEOUT = 4'h1;
	localparam logic [3:0] SIR_REG_PARAM = 4'h2;
	localparam logic [3:0] SIR_REG_DEST = 4'h3;
	localparam logic [3:0] SIR_REG_CANCEL = 4'h4;
	localparam logic [3:0] SIR_REG_STATUS = 4'h5;
	localparam logic [3:0] SIR_REG_PORT_STATUS = 4'h6;
	localparam logic [3:0] SIR_REG_MOVED = 4'h7;
	localparam logic [3:0] SIR_REG_LEFT = 4'h8;
	// Command codes
	localparam logic [15:0] SIR_CMD_INIT_PORT = 16'h10cc;
	localparam logic [15:0] SIR_CMD_CANCEL = 16'h112f;
	localparam logic [15:0] SIR_CMD_READ_BYTES = 16'h1132;
	localparam logic [15:0] SIR_CMD_READ_STRING = 16'h1133;
	// Cancel transaction types
	localparam logic [15:0] SIR_CANCEL_ALL = 16'h0001;
	localparam logic [15:0] SIR_CANCEL_READ = 16'h0002;
	localparam logic [15:0] SIR_CANCEL_WRITE = 16'h0003;
	// Status word values: minor code in high byte, major in low byte
	localparam logic [15:0] SIR_ST_RESET = 16'h0000;
	localparam logic [15:0] SIR_ST_OK = 16'h0001;
	localparam logic [15:0] SIR_ST_CANCELLED = 16'h120c;
	localparam logic [15:0] SIR_ST_TIMEOUT = 16'h130c;
	localparam logic [15:0] SIR_ST_BUSY = 16'h140c;
	localparam logic [15:0] SIR_ST_BAD_PARAM = 16'h150c;
	// Port status bit positions
	localparam int SIR_PS_DONE_DATA = 0;
	localparam int SIR_PS_DONE_TIMEOUT = 1;
	localparam int SIR_PS_OVERFLOW = 2;
	// Return block layout
	localparam logic [15:0] SIR_RET_MOVED = 16'h0000;
	localparam logic [15:0] SIR_RET_LEFT = 16'h0001;
	localparam logic [15:0] SIR_RET_DATA = 16'h0002;
	// Receive buffer shape
	localparam int SIR_BUF_DEPTH = 256;
	localparam int SIR_BUF_AW = 8;
	localparam logic [7:0] SIR_TERM_MAX = 8'hff;
	// Time-out unit
	localparam int SIR_CLOCK_HZ = 250000000;
	localparam int SIR_SECOND_S = 1;
	localparam int SIR_CYCLES_PER_SECOND = SIR_CLOCK_HZ * SIR_SECOND_S;
	// Read engine states
	typedef enum logic [2:0] {
		SIR_IDLE = 3'b000,
		SIR_WAIT = 3'b001,
		SIR_DATA = 3'b010,
		SIR_HDR0 = 3'b011,
		SIR_HDR1 = 3'b100
	} sir_state_t;
endpackage

//--- sir_rx_buffer.sv
// Purpose: Internal receive buffer holding characters from the serial port
// Assumes: Push and pop come from logic on the same clock
// Notes: A push into a full buffer is dropped and flagged for one cycle
`timescale 1ns/10ps
`default_nettype none
module sir_rx_buffer
	import sir_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic flush_i,
	input wire logic push_i,
	input wire logic [7:0] push_data_i,
	input wire logic pop_i,
	input wire logic [SIR_BUF_AW-1:0] peek_ofs_i,
	output logic [7:0] head_o,
	output logic [7:0] peek_o,
	output logic [SIR_BUF_AW:0] count_o,
	output logic overflow_o
);
	logic [7:0] mem [0:SIR_BUF_DEPTH-1];
	logic [SIR_BUF_AW-1:0] wr_ptr;
	logic [SIR_BUF_AW-1:0] rd_ptr;
	logic full;
	logic do_push;
	logic do_pop;

	// Drop on full, pop only what is held
	assign full = (count_o == (SIR_BUF_AW+1)'(SIR_BUF_DEPTH));
	assign do_push = push_i && !full && !flush_i;
	assign do_pop = pop_i && (count_o != '0) && !flush_i;
	assign head_o = mem[rd_ptr];
	assign peek_o = mem[SIR_BUF_AW'(rd_ptr + peek_ofs_i)];

	// Storage array
	always_ff @(posedge clock_i)
	begin
		if (do_push)
			mem[wr_ptr] <= push_data_i;
	end

	// Pointers and fill count
	always_ff @(posedge clock_i)
	begin
		if (rst_i || flush_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count_o <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (do_push && !do_pop)
				count_o <= count_o + 1'b1;
			else if (do_pop && !do_push)
				count_o <= count_o - 1'b1;
		end
	end

	// One-cycle pulse for a character lost to a full buffer
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			overflow_o <= 1'b0;
		else
			overflow_o <= push_i && full && !flush_i;
	end
endmodule
`default_nettype wire

//--- sir_read_engine.sv
// Purpose: Command-driven serial input read engine with receive buffer
// Assumes: Received characters arrive as a valid strobe on this clock
// Notes: Returned data goes out over a word memory write port
// Summary of operation
// - Port init or cancel all/write halts string transmission
// - Byte read moves chars, reports moved and left
// - Zero count returns only buffered count
// - Short buffer keeps read pending until data/time-out
// - Status word untouched while read pending, except a second read sets busy
// - Zero byte-read time-out waits without limit
// - Failed read writes nothing, keeps buffered chars
// - Return: moved, left, chars two per word
// - Odd byte count leaves last high byte
// - Buffer all chars; full drops and flags overflow
// - String read moves through terminator, 0 to 255
// - String read pends until terminator or time-out
// - Zero string-read time-out waits for terminator
// - Cancel keeps buffered chars, port not reset
// - Cancelled command reports minor code 12H
`timescale 1ns/10ps
`default_nettype none
module sir_read_engine
	import sir_pkg::*;
#(
	parameter int CYCLES_PER_SECOND = SIR_CYCLES_PER_SECOND
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [15:0] reg_rdata_o,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic tx_busy_i,
	output logic tx_halt_o,
	output logic mem_we_o,
	output logic [15:0] mem_addr_o,
	output logic [15:0] mem_data_o,
	output logic [1:0] mem_be_o,
	output logic read_pending_o
);
	sir_state_t state;
	logic [15:0] timeout_reg;
	logic [15:0] param_reg;
	logic [15:0] dest_reg;
	logic [15:0] status_word;
	logic [2:0] port_status;
	logic [15:0] moved_reg;
	logic op_string;
	logic [15:0] req_count;
	logic [7:0] term_char;
	logic [15:0] secs_left;
	logic tmo_enabled;
	logic [31:0] sec_div;
	logic sec_tick;
	logic [SIR_BUF_AW-1:0] scan_idx;
	logic [15:0] xfer_len;
	logic [15:0] moved;
	logic [15:0] waddr;
	logic [7:0] lo_byte;
	logic half;
	logic [7:0] head;
	logic [7:0] peek;
	logic [SIR_BUF_AW:0] buf_count;
	logic buf_ovf;
	logic pop;
	logic cmd_wr;
	logic is_init;
	logic is_cancel;
	logic abort_read;
	logic start_read;
	logic timed_out;
	logic [15:0] buf_count16;

	assign buf_count16 = {{(15-SIR_BUF_AW){1'b0}}, buf_count};
	assign cmd_wr = reg_write_i && (reg_addr_i == SIR_REG_CMD);
	assign is_init = cmd_wr && (reg_wdata_i == SIR_CMD_INIT_PORT);
	assign is_cancel = reg_write_i && (reg_addr_i == SIR_REG_CANCEL);
	// Cancel all/read or port init aborts a pending read
	assign abort_read = is_init || (is_cancel && (reg_wdata_i == SIR_CANCEL_ALL ||
		reg_wdata_i == SIR_CANCEL_READ));
	assign start_read = cmd_wr && (reg_wdata_i == SIR_CMD_READ_BYTES || reg_wdata_i == SIR_CMD_READ_STRING);
	assign timed_out = tmo_enabled && sec_tick && (secs_left == 16'h0001);
	assign pop = (state == SIR_DATA);
	assign read_pending_o = (state != SIR_IDLE);

	// Receive buffer: only port init flushes it, cancel leaves it alone
	sir_rx_buffer u_rx_buffer (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.flush_i(is_init),
		.push_i(rx_valid_i),
		.push_data_i(rx_data_i),
		.pop_i(pop),
		.peek_ofs_i(scan_idx),
		.head_o(head),
		.peek_o(peek),
		.count_o(buf_count),
		.overflow_o(buf_ovf)
	);

	// Command block parameters written by software
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			timeout_reg <= 16'h0000;
			param_reg <= 16'h0000;
			dest_reg <= 16'h0000;
		end
		else if (reg_write_i)
		begin
			if (reg_addr_i == SIR_REG_TIMEOUT)
				timeout_reg <= reg_wdata_i;
			if (reg_addr_i == SIR_REG_PARAM)
				param_reg <= reg_wdata_i;
			if (reg_addr_i == SIR_REG_DEST)
				dest_reg <= reg_wdata_i;
		end
	end

	// Halt request to the transmitter for one cycle
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			tx_halt_o <= 1'b0;
		else
			tx_halt_o <= tx_busy_i && (is_init || (is_cancel && (reg_wdata_i == SIR_CANCEL_ALL ||
				reg_wdata_i == SIR_CANCEL_WRITE)));
	end

	// One-second enable, restarted when a read starts
	always_ff @(posedge clock_i)
	begin
		if (rst_i || state == SIR_IDLE)
		begin
			sec_div <= 32'h00000000;
			sec_tick <= 1'b0;
		end
		else if (sec_div == 32'(CYCLES_PER_SECOND - 1))
		begin
			sec_div <= 32'h00000000;
			sec_tick <= 1'b1;
		end
		else
		begin
			sec_div <= sec_div + 32'h00000001;
			sec_tick <= 1'b0;
		end
	end

	// Port status: completion reason and sticky overflow
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			port_status <= 3'b000;
		else
		begin
			if (state == SIR_HDR1)
			begin
				port_status[SIR_PS_DONE_DATA] <= 1'b1;
				port_status[SIR_PS_DONE_TIMEOUT] <= 1'b0;
			end
			else if (state == SIR_WAIT && timed_out && !abort_read)
			begin
				port_status[SIR_PS_DONE_DATA] <= 1'b0;
				port_status[SIR_PS_DONE_TIMEOUT] <= 1'b1;
			end
			// A new overflow wins over the clear by port init
			if (buf_ovf)
				port_status[SIR_PS_OVERFLOW] <= 1'b1;
			else if (is_init)
				port_status[SIR_PS_OVERFLOW] <= 1'b0;
		end
	end

	// Read engine, status word and memory write port
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state <= SIR_IDLE;
			status_word <= SIR_ST_RESET;
			moved_reg <= 16'h0000;
			op_string <= 1'b0;
			req_count <= 16'h0000;
			term_char <= 8'h00;
			secs_left <= 16'h0000;
			tmo_enabled <= 1'b0;
			scan_idx <= '0;
			xfer_len <= 16'h0000;
			moved <= 16'h0000;
			waddr <= 16'h0000;
			lo_byte <= 8'h00;
			half <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 16'h0000;
			mem_data_o <= 16'h0000;
			mem_be_o <= 2'b00;
		end
		else
		begin
			mem_we_o <= 1'b0;
			unique case (state)
				SIR_IDLE:
				begin
					if (start_read)
					begin
						if (reg_wdata_i == SIR_CMD_READ_STRING && param_reg > {8'h00, SIR_TERM_MAX})
							status_word <= SIR_ST_BAD_PARAM;
						else
						begin
							op_string <= (reg_wdata_i == SIR_CMD_READ_STRING);
							req_count <= param_reg;
							term_char <= param_reg[7:0];
							secs_left <= timeout_reg;
							tmo_enabled <= (timeout_reg != 16'h0000);
							scan_idx <= '0;
							moved <= 16'h0000;
							half <= 1'b0;
							waddr <= dest_reg + SIR_RET_DATA;
							state <= SIR_WAIT;
						end
					end
				end
				SIR_WAIT:
				begin
					// Status word is left alone until completion, except a second read command sets it busy
					if (start_read)
						status_word <= SIR_ST_BUSY;
					if (abort_read)
					begin
						status_word <= SIR_ST_CANCELLED;
						state <= SIR_IDLE;
					end
					else if (!op_string && req_count == 16'h0000)
					begin
						xfer_len <= 16'h0000;
						state <= SIR_HDR0;
					end
					else if (!op_string && buf_count16 >= req_count)
					begin
						xfer_len <= req_count;
						state <= SIR_DATA;
					end
					else if (op_string && {1'b0, scan_idx} < buf_count && peek == term_char)
					begin
						xfer_len <= 16'({1'b0, scan_idx}) + 16'h0001;
						state <= SIR_DATA;
					end
					else if (timed_out)
					begin
						status_word <= SIR_ST_TIMEOUT;
						state <= SIR_IDLE;
					end
					else
					begin
						if (op_string && {1'b0, scan_idx} < buf_count && scan_idx != SIR_BUF_AW'(SIR_BUF_DEPTH - 1))
							scan_idx <= scan_idx + 1'b1;
						if (sec_tick && tmo_enabled)
							secs_left <= secs_left - 16'h0001;
					end
				end
				SIR_DATA:
				begin
					// Pair bytes, first one in the low half
					moved <= moved + 16'h0001;
					if (!half)
					begin
						lo_byte <= head;
						half <= 1'b1;
						if (moved + 16'h0001 == xfer_len)
						begin
							mem_we_o <= 1'b1;
							mem_addr_o <= waddr;
							mem_data_o <= {8'h00, head};
							mem_be_o <= 2'b01;
							state <= SIR_HDR0;
						end
					end
					else
					begin
						half <= 1'b0;
						mem_we_o <= 1'b1;
						mem_addr_o <= waddr;
						mem_data_o <= {head, lo_byte};
						mem_be_o <= 2'b11;
						waddr <= waddr + 16'h0001;
						if (moved + 16'h0001 == xfer_len)
							state <= SIR_HDR0;
					end
				end
				SIR_HDR0:
				begin
					mem_we_o <= 1'b1;
					mem_addr_o <= dest_reg + SIR_RET_MOVED;
					mem_data_o <= moved;
					mem_be_o <= 2'b11;
					moved_reg <= moved;
					state <= SIR_HDR1;
				end
				SIR_HDR1:
				begin
					mem_we_o <= 1'b1;
					mem_addr_o <= dest_reg + SIR_RET_LEFT;
					mem_data_o <= buf_count16;
					mem_be_o <= 2'b11;
					status_word <= SIR_ST_OK;
					state <= SIR_IDLE;
				end
				default:
					state <= SIR_IDLE;
			endcase
		end
	end

	// Register read data, one cycle after the strobe
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			reg_rdata_o <= 16'h0000;
		else if (reg_read_i)
		begin
			unique case (reg_addr_i)
				SIR_REG_TIMEOUT: reg_rdata_o <= timeout_reg;
				SIR_REG_PARAM: reg_rdata_o <= param_reg;
				SIR_REG_DEST: reg_rdata_o <= dest_reg;
				SIR_REG_STATUS: reg_rdata_o <= status_word;
				SIR_REG_PORT_STATUS: reg_rdata_o <= {13'h0000, port_status};
				SIR_REG_MOVED: reg_rdata_o <= moved_reg;
				SIR_REG_LEFT: reg_rdata_o <= buf_count16;
				default: reg_rdata_o <= 16'h0000;
			endcase
		end
		else
			reg_rdata_o <= 16'h0000;
	end
endmodule
`default_nettype wire

//--- sir_read_monitor.sv
// Purpose: Port checker for the serial input read engine
// Assumes: One clock, synchronous active high reset
// Notes: Bound to every engine instance
`timescale 1ns/10ps
`default_nettype none
module sir_read_monitor
	import sir_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic tx_busy_i,
	input wire logic tx_halt_o,
	input wire logic mem_we_o,
	input wire logic [1:0] mem_be_o,
	input wire logic read_pending_o
);
	default clocking dc @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	// Decoded register writes
	wire logic cmd_w = reg_write_i && reg_addr_i == SIR_REG_CMD;
	wire logic can_w = reg_write_i && reg_addr_i == SIR_REG_CANCEL;
	wire logic halt_w = (can_w && reg_wdata_i inside {SIR_CANCEL_ALL, SIR_CANCEL_WRITE})
		|| (cmd_w && reg_wdata_i == SIR_CMD_INIT_PORT);
	// Transmit halt, read data, command start and end
	halt_on_stop_a: assert property (halt_w && tx_busy_i |=> tx_halt_o)
		else $error("halt pulse missing");
	halt_one_cycle_a: assert property (tx_halt_o |=> !tx_halt_o)
		else $error("halt pulse too long");
	rdata_quiet_a: assert property (!reg_read_i |=> reg_rdata_o == 16'h0000)
		else $error("read data without strobe");
	read_starts_a: assert property (cmd_w && reg_wdata_i == SIR_CMD_READ_BYTES && !read_pending_o
		|=> read_pending_o)
		else $error("byte read not started");
	// The closing header write stands in the cycle in which pending has just dropped
	idle_no_write_a: assert property (!read_pending_o && !$past(read_pending_o) |-> !mem_we_o)
		else $error("memory write while idle");
	byte_enable_a: assert property (mem_we_o |-> mem_be_o inside {2'b11, 2'b01})
		else $error("bad byte enables");
	// Port init aborts a read on purpose, so it is left out here
	busy_keeps_a: assert property (cmd_w && reg_wdata_i != SIR_CMD_INIT_PORT && read_pending_o && !mem_we_o
		|=> read_pending_o)
		else $error("second command broke pending read");
	cancel_ends_a: assert property (can_w && reg_wdata_i == SIR_CANCEL_READ && read_pending_o
		|-> ##[1:3] !read_pending_o)
		else $error("cancel did not end read");
	// Main scenarios
	halt_c: cover property (tx_halt_o);
	odd_byte_c: cover property (mem_we_o && mem_be_o == 2'b01);
	cancel_c: cover property (can_w && read_pending_o);
endmodule
bind sir_read_engine sir_read_monitor i_mon (.clock_i(clock_i), .rst_i(rst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
	.reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .tx_busy_i(tx_busy_i),
	.tx_halt_o(tx_halt_o), .mem_we_o(mem_we_o), .mem_be_o(mem_be_o),
	.read_pending_o(read_pending_o));
`default_nettype wire

//--- sir_remote_model.sv
// Purpose: Remote serial device sending characters into the port
// Assumes: Characters arrive as one-cycle strobes
// Notes: Idle data shows the inverse of the last byte
`timescale 1ns/10ps
`default_nettype none
module sir_remote_model
(
	input wire logic clock_i,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o
);
	// Quiet line at time zero
	initial
	begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
	end
	// One character per call; stale data flips so it never passes as fresh
	task automatic send(input logic [7:0] ch);
		@(posedge clock_i);
		rx_valid_o <= 1'b1;
		rx_data_o <= ch;
		@(posedge clock_i);
		rx_valid_o <= 1'b0;
		rx_data_o <= ~ch;
	endtask
endmodule
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for the serial input read engine
// Assumes: Time-out second shortened to 10 cycles
// Notes: Input area is mirrored in a local word array
`timescale 1ns/10ps
`default_nettype none
module tb
	import sir_pkg::*;
;
	logic clock_i;
	logic rst_i;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic tx_busy;
	wire logic [15:0] reg_rdata;
	wire logic rx_valid;
	wire logic [7:0] rx_data;
	wire logic tx_halt;
	wire logic mem_we;
	wire logic [15:0] mem_addr;
	wire logic [15:0] mem_data;
	wire logic [1:0] mem_be;
	wire logic read_pending;
	logic [15:0] mem [0:255];
	logic [15:0] got;
	logic [3:0] stop_a [3] = '{SIR_REG_CANCEL, SIR_REG_CANCEL, SIR_REG_CMD};
	logic [15:0] stop_d [3] = '{SIR_CANCEL_ALL, SIR_CANCEL_WRITE, SIR_CMD_INIT_PORT};
	int err_count = 0;
	int comparisons = 0;
	sir_read_engine #(.CYCLES_PER_SECOND(10)) i_sir_read_engine (.clock_i(clock_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
		.reg_rdata_o(reg_rdata), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .tx_busy_i(tx_busy),
		.tx_halt_o(tx_halt), .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_data_o(mem_data),
		.mem_be_o(mem_be), .read_pending_o(read_pending));
	sir_remote_model i_sir_remote_model (.clock_i(clock_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data));
	// Clock
	initial
	begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	// Mirror of the input area, byte enables honoured
	always @(posedge clock_i)
	begin
		if (mem_we === 1'b1)
		begin
			if (mem_be[0]) mem[mem_addr[7:0]][7:0] <= mem_data[7:0];
			if (mem_be[1]) mem[mem_addr[7:0]][15:8] <= mem_data[15:8];
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_i);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock_i);
		reg_write <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m, input string n);
		@(posedge clock_i);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock_i);
		reg_read <= 1'b0;
		#1;
		chk(n, e, reg_rdata & m);
	endtask
	task automatic start(input logic [15:0] c, input logic [15:0] t, input logic [15:0] p, input logic [15:0] d);
		wr(SIR_REG_TIMEOUT, t);
		wr(SIR_REG_PARAM, p);
		wr(SIR_REG_DEST, d);
		wr(SIR_REG_CMD, c);
		#1;
	endtask
	// Wait for the read to end, then one more edge so the mirror holds the last write
	task automatic idle;
		for (int i = 0; i < 400 && read_pending !== 1'b0; i++) @(posedge clock_i) #1;
		@(posedge clock_i) #1;
		chk("pending", 16'h0000, {15'h0000, read_pending});
	endtask
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#40000;
		err_count++;
		print_verdict;
	end
	// Main sequence
	initial
	begin
		rst_i = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		tx_busy = 1'b0;
		for (int i = 0; i < 256; i++) mem[i] = 16'haaaa;
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		rchk(SIR_REG_STATUS, SIR_ST_RESET, 16'hffff, "status");
		i_sir_remote_model.send(8'h11);
		i_sir_remote_model.send(8'h22);
		i_sir_remote_model.send(8'h33);
		start(SIR_CMD_READ_BYTES, 16'h0001, 16'h0003, 16'h0010);
		idle;
		chk("pair", 16'h2211, mem[18]);
		chk("odd", 16'haa33, mem[19]);
		chk("moved", 16'h0003, mem[16]);
		chk("left", 16'h0000, mem[17]);
		rchk(SIR_REG_STATUS, SIR_ST_OK, 16'hffff, "status");
		rchk(SIR_REG_PORT_STATUS, 16'h0001, 16'h0003, "reason");
		i_sir_remote_model.send(8'h44);
		i_sir_remote_model.send(8'h55);
		start(SIR_CMD_READ_BYTES, 16'h0000, 16'h0000, 16'h0020);
		idle;
		chk("zero moved", 16'h0000, mem[32]);
		chk("zero left", 16'h0002, mem[33]);
		chk("zero data", 16'haaaa, mem[34]);
		start(SIR_CMD_READ_BYTES, 16'h0000, 16'h0004, 16'h0028);
		repeat (30) @(posedge clock_i);
		rchk(SIR_REG_STATUS, SIR_ST_OK, 16'hffff, "pending status");
		chk("waits", 16'h0001, {15'h0000, read_pending});
		wr(SIR_REG_CMD, SIR_CMD_READ_BYTES);
		rchk(SIR_REG_STATUS, SIR_ST_BUSY, 16'hffff, "busy");
		i_sir_remote_model.send(8'h66);
		i_sir_remote_model.send(8'h77);
		idle;
		chk("late pair", 16'h7766, mem[43]);
		chk("late moved", 16'h0004, mem[40]);
		i_sir_remote_model.send(8'h88);
		start(SIR_CMD_READ_BYTES, 16'h0001, 16'h0003, 16'h0030);
		idle;
		rchk(SIR_REG_STATUS, SIR_ST_TIMEOUT, 16'hffff, "timeout");
		rchk(SIR_REG_PORT_STATUS, 16'h0002, 16'h0003, "reason");
		chk("no data", 16'haaaa, mem[48]);
		rchk(SIR_REG_LEFT, 16'h0001, 16'hffff, "kept");
		start(SIR_CMD_READ_STRING, 16'h0000, 16'h000d, 16'h0038);
		repeat (30) @(posedge clock_i);
		chk("no term", 16'h0001, {15'h0000, read_pending});
		wr(SIR_REG_CANCEL, SIR_CANCEL_READ);
		idle;
		rchk(SIR_REG_STATUS, SIR_ST_CANCELLED, 16'hffff, "cancel");
		rchk(SIR_REG_LEFT, 16'h0001, 16'hffff, "kept");
		chk("no data", 16'haaaa, mem[56]);
		i_sir_remote_model.send(8'h0d);
		i_sir_remote_model.send(8'h99);
		start(SIR_CMD_READ_STRING, 16'h0001, 16'h000d, 16'h0038);
		idle;
		chk("str moved", 16'h0002, mem[56]);
		chk("str left", 16'h0001, mem[57]);
		chk("str data", 16'h0d88, mem[58]);
		start(SIR_CMD_READ_STRING, 16'h0000, 16'h000d, 16'h0040);
		i_sir_remote_model.send(8'h0d);
		idle;
		chk("str late", 16'h0d99, mem[66]);
		start(SIR_CMD_READ_STRING, 16'h0000, 16'h0100, 16'h0048);
		rchk(SIR_REG_STATUS, SIR_ST_BAD_PARAM, 16'hffff, "term range");
		idle;
		for (int i = 0; i < 257; i++) i_sir_remote_model.send(i[7:0]);
		repeat (3) @(posedge clock_i);
		rchk(SIR_REG_PORT_STATUS, 16'h0004, 16'h0004, "overflow");
		rchk(SIR_REG_LEFT, 16'h0100, 16'hffff, "full");
		@(posedge clock_i);
		tx_busy <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			wr(stop_a[i], stop_d[i]);
			#1;
			chk("halt", 16'h0001, {15'h0000, tx_halt});
			@(posedge clock_i) #1;
			chk("halt end", 16'h0000, {15'h0000, tx_halt});
		end
		rchk(SIR_REG_LEFT, 16'h0000, 16'hffff, "flushed");
		rchk(SIR_REG_PORT_STATUS, 16'h0000, 16'h0004, "overflow clear");
		print_verdict;
	end
endmodule
`default_nettype wire
